//--- audio_dac_front.sv
// Purpose: converter front end: power-on init, serial input, clock watch, muting
// Assumes: link clocks synchronous to ref_clk, bit clock is the link domain
// Notes: outputs are 24-bit MSB-aligned codes, zero is mid-scale
// Function
// - master clock ratio limited per sample rate
// - 1024 master cycles of init after reset
// - outputs held mid-scale during init
// - defaults loaded one cycle after init
// - data sampled on bit clock rising edge
// - source keeps link clocks synchronous to master
// - word select toggles once per sample
// - bit clock 48 or 64 fs, 32 RJ16
// - suspend on rate change or clock stall
// - self resync in under three periods
// - mute during resync plus three periods
// - format chosen by three-bit format field
// - reset format is 24-bit left-justified
// - words MSB first, two's complement
// - standard and LJ: high means left
// - I2S: low means left
// - separate or joint zero flag outputs
// - word lengths 16, 18, 20, 24
`timescale 1ns/1ns
module audio_dac_front #(
  parameter int INIT_COUNT = audio_pkg::INIT_CYCLES,
  parameter int RATE_TOLERANCE = audio_pkg::RATE_TOL
) (
  input wire logic ref_clk, // master clock
  input wire logic sys_rst, // async reset, high
  audio_link_if.device link, // serial audio input
  input wire logic [2:0] inputFormatField, // format to write
  input wire logic formatWrite, // one-cycle write strobe
  input wire logic jointZeroMode, // 1: joint flag on right pin
  output logic [audio_pkg::SAMPLE_W-1:0] leftChannelOutput, // left code
  output logic [audio_pkg::SAMPLE_W-1:0] rightChannelOutput, // right code
  output logic sampleStrobe, // pulse on output update
  output logic leftZeroFlag, // left zero, 0 in joint mode
  output logic rightZeroFlag, // right or joint zero
  output logic converterRunning, // normal conversion
  output logic [15:0] measuredRatio // master cycles per frame
);
  import audio_pkg::*;

  if (INIT_COUNT < 1 || INIT_COUNT > 2047 || RATE_TOLERANCE < 1) begin : gBadParam
    $error("audio_dac_front: unsupported parameter value");
  end

  typedef enum logic [2:0] {ST_INIT, ST_LOAD, ST_SYNC, ST_MUTE, ST_RUN} front_state_e;

  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  front_state_e state_reg;
  logic [2:0] formatReg;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: capture on bit clock
  logic [2:0] fmtMeta_reg;
  logic [2:0] fmtSync_reg;
  logic wsPrev_reg;
  logic [5:0] pos_reg;
  logic [4:0] taken_reg;
  logic [SAMPLE_W-1:0] shift_reg;
  logic [SAMPLE_W-1:0] word_reg;
  logic wordLeft_reg;
  logic wordToggle_reg;
  format_mode_e linkMode;
  logic [4:0] linkLen;
  logic wsChange;
  logic [5:0] posNow;
  logic take;
  logic [SAMPLE_W-1:0] shiftBase;
  logic [4:0] justifyAmt;

  always_ff @(posedge link.audioBitClock or posedge sys_rst) begin
    if (sys_rst) begin
      fmtMeta_reg <= FMT_RESET;
      fmtSync_reg <= FMT_RESET;
    end else begin
      fmtMeta_reg <= formatReg;
      fmtSync_reg <= fmtMeta_reg;
    end
  end

  always_comb begin
    linkMode = fmtMode(fmtSync_reg);
    linkLen = fmtLength(fmtSync_reg);
    wsChange = link.wordSelectClock != wsPrev_reg;
    posNow = wsChange ? 6'h00 : pos_reg;
    case (linkMode)
      MODE_RJ: take = 1'b1;
      MODE_I2S: take = (posNow >= 6'h01) && (posNow <= 6'h18);
      default: take = posNow < 6'h18;
    endcase
    shiftBase = wsChange ? BIPOLAR_ZERO : shift_reg;
    if (linkMode == MODE_RJ) begin
      justifyAmt = 5'(SAMPLE_W) - linkLen;
    end else begin
      justifyAmt = 5'(SAMPLE_W) - taken_reg;
    end
  end

  always_ff @(posedge link.audioBitClock or posedge sys_rst) begin
    if (sys_rst) begin
      wsPrev_reg <= 1'b0;
      pos_reg <= 6'h00;
      taken_reg <= 5'h00;
      shift_reg <= BIPOLAR_ZERO;
    end else begin
      wsPrev_reg <= link.wordSelectClock;
      pos_reg <= (posNow == 6'h3F) ? posNow : posNow + 6'h01;
      if (take) begin
        shift_reg <= {shiftBase[SAMPLE_W-2:0], link.serialData};
      end else begin
        shift_reg <= shiftBase;
      end
      if (wsChange) begin
        taken_reg <= take ? 5'h01 : 5'h00;
      end else if (take && taken_reg != 5'h18) begin
        taken_reg <= taken_reg + 5'h01;
      end
    end
  end

  // word closes at the word select edge; held until the next edge
  always_ff @(posedge link.audioBitClock or posedge sys_rst) begin
    if (sys_rst) begin
      word_reg <= BIPOLAR_ZERO;
      wordLeft_reg <= 1'b0;
      wordToggle_reg <= 1'b0;
    end else if (wsChange) begin
      word_reg <= shift_reg << justifyAmt;
      wordLeft_reg <= wsPrev_reg == leftLevel(linkMode);
      wordToggle_reg <= ~wordToggle_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master domain: synchronisers and clock watch
  logic [2:0] linkMeta_reg;
  logic [2:0] linkSync_reg;
  logic [2:0] linkLast_reg;
  logic bckRise;
  logic wsRise;
  logic wordEvent;
  logic [15:0] bitGap_reg;
  logic [15:0] bitPeriod_reg;
  logic [15:0] wsCount_reg;
  logic [15:0] wsPeriod_reg;
  logic [17:0] stallLimit;
  logic [15:0] wsDiff;
  logic stall;
  logic rateChange;
  logic suspend;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      linkMeta_reg <= 3'h0;
      linkSync_reg <= 3'h0;
      linkLast_reg <= 3'h0;
    end else begin
      linkMeta_reg <= {wordToggle_reg, link.wordSelectClock, link.audioBitClock};
      linkSync_reg <= linkMeta_reg;
      linkLast_reg <= linkSync_reg;
    end
  end

  always_comb begin
    bckRise = linkSync_reg[0] & ~linkLast_reg[0];
    wsRise = linkSync_reg[1] & ~linkLast_reg[1];
    wordEvent = linkSync_reg[2] ^ linkLast_reg[2];
    stallLimit = 18'(STALL_BIT_PERIODS) * {2'b00, bitPeriod_reg};
    wsDiff = (wsCount_reg > wsPeriod_reg) ? wsCount_reg - wsPeriod_reg
                                          : wsPeriod_reg - wsCount_reg;
    stall = ({2'b00, bitGap_reg} > stallLimit) || (wsCount_reg == CNT_MAX);
    rateChange = wsRise && (wsDiff > 16'(RATE_TOLERANCE));
    suspend = stall || rateChange;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitGap_reg <= 16'h0000;
      bitPeriod_reg <= 16'h0000;
    end else if (bckRise) begin
      bitGap_reg <= 16'h0001;
      bitPeriod_reg <= bitGap_reg;
    end else if (bitGap_reg != CNT_MAX) begin
      bitGap_reg <= bitGap_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wsCount_reg <= 16'h0000;
      wsPeriod_reg <= 16'h0000;
    end else if (wsRise) begin
      wsCount_reg <= 16'h0001;
      wsPeriod_reg <= wsCount_reg;
    end else if (wsCount_reg != CNT_MAX) begin
      wsCount_reg <= wsCount_reg + 16'h0001;
    end
  end

  assign measuredRatio = wsPeriod_reg;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: init, default load, resync, mute, run
  logic [10:0] initCnt_reg;
  logic [1:0] periodCnt_reg;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_INIT;
      initCnt_reg <= 11'h000;
      periodCnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_INIT: begin
          initCnt_reg <= initCnt_reg + 11'h001;
          if (initCnt_reg == 11'(INIT_COUNT - 1)) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          periodCnt_reg <= 2'h0;
          state_reg <= ST_SYNC;
        end
        ST_SYNC: begin
          if (suspend) begin
            periodCnt_reg <= 2'h0;
          end else if (wsRise) begin
            periodCnt_reg <= periodCnt_reg + 2'h1;
            if (periodCnt_reg == 2'(SYNC_PERIODS - 1)) begin
              periodCnt_reg <= 2'h0;
              state_reg <= ST_MUTE;
            end
          end
        end
        ST_MUTE: begin
          if (suspend) begin
            periodCnt_reg <= 2'h0;
            state_reg <= ST_SYNC;
          end else if (wsRise) begin
            periodCnt_reg <= periodCnt_reg + 2'h1;
            if (periodCnt_reg == 2'(MUTE_PERIODS - 1)) begin
              state_reg <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (suspend) begin
            periodCnt_reg <= 2'h0;
            state_reg <= ST_SYNC;
          end
        end
        default: state_reg <= ST_INIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      formatReg <= FMT_RESET;
    end else if (state_reg == ST_LOAD) begin
      formatReg <= FMT_RESET;
    end else if (formatWrite && state_reg != ST_INIT) begin
      formatReg <= inputFormatField;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: word data is stable long after its toggle is seen
  logic leftZero;
  logic rightZero;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      leftChannelOutput <= BIPOLAR_ZERO;
      rightChannelOutput <= BIPOLAR_ZERO;
      sampleStrobe <= 1'b0;
    end else if (state_reg != ST_RUN || suspend) begin
      leftChannelOutput <= BIPOLAR_ZERO;
      rightChannelOutput <= BIPOLAR_ZERO;
      sampleStrobe <= 1'b0;
    end else begin
      sampleStrobe <= wordEvent;
      if (wordEvent && wordLeft_reg) begin
        leftChannelOutput <= word_reg;
      end
      if (wordEvent && !wordLeft_reg) begin
        rightChannelOutput <= word_reg;
      end
    end
  end

  assign leftZero = leftChannelOutput == BIPOLAR_ZERO;
  assign rightZero = rightChannelOutput == BIPOLAR_ZERO;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      leftZeroFlag <= 1'b0;
      rightZeroFlag <= 1'b0;
      converterRunning <= 1'b0;
    end else begin
      leftZeroFlag <= jointZeroMode ? 1'b0 : leftZero;
      rightZeroFlag <= jointZeroMode ? (leftZero & rightZero) : rightZero;
      converterRunning <= state_reg == ST_RUN;
    end
  end
endmodule

//--- audio_link_asserts.sv
// Purpose: concurrent checks on the serial audio link and the converter outputs
// Assumes: one ref_clk domain; host bit clock made by division of ref_clk
// Notes: hostRst is the reset actually seen by the source end
`timescale 1ns/1ns
module audio_link_asserts #(
  parameter int INIT_COUNT = audio_pkg::INIT_CYCLES
) (
  input wire logic ref_clk, // master clock
  input wire logic sys_rst, // converter reset
  input wire logic hostRst, // source reset
  input wire logic audioBitClock, // link bit clock
  input wire logic wordSelectClock, // link word select
  input wire logic serialData, // link data
  input wire logic converterRunning, // run state
  input wire logic [audio_pkg::SAMPLE_W-1:0] leftChannelOutput, // left code
  input wire logic [audio_pkg::SAMPLE_W-1:0] rightChannelOutput, // right code
  input wire logic sampleStrobe, // word delivered
  input wire logic leftZeroFlag, // left zero
  input wire logic rightZeroFlag, // right or joint zero
  input wire logic jointZeroMode, // flag mode
  input wire logic [15:0] measuredRatio, // cycles per frame
  input wire logic sampleReady, // buffer not full
  input wire logic underrun // zero frame sent
);
  import audio_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] cycReg;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) cycReg <= 16'h0000;
    else if (cycReg != 16'hFFFF) cycReg <= cycReg + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_init_span: assert property (disable iff (sys_rst)
    converterRunning |-> cycReg > INIT_COUNT) else $error("run before init ended");
  chk_mute_zero: assert property (disable iff (sys_rst)
    !converterRunning |-> leftChannelOutput == BIPOLAR_ZERO && rightChannelOutput == BIPOLAR_ZERO)
    else $error("outputs not mid-scale while muted");
  chk_bck_rate: assert property (disable iff (hostRst)
    $rose(audioBitClock) |-> ##4 $rose(audioBitClock)) else $error("bit clock period wrong");
  chk_ws_rate: assert property (disable iff (hostRst)
    $changed(wordSelectClock) |-> ##128 $changed(wordSelectClock))
    else $error("word select period wrong");
  chk_edge_align: assert property (disable iff (hostRst)
    $changed(wordSelectClock) || $changed(serialData) |-> $fell(audioBitClock))
    else $error("link line moved off a falling bit clock");
  chk_ratio_count: assert property (disable iff (sys_rst)
    converterRunning |-> measuredRatio == 16'h0100) else $error("frame ratio wrong");
  chk_zero_flags: assert property (disable iff (sys_rst)
    !$past(sys_rst) |-> leftZeroFlag == $past(!jointZeroMode && leftChannelOutput == 24'h000000)
    && rightZeroFlag == $past(jointZeroMode ? (leftChannelOutput == 24'h000000
    && rightChannelOutput == 24'h000000) : rightChannelOutput == 24'h000000))
    else $error("zero flags wrong");
  chk_one_strobe: assert property (disable iff (sys_rst)
    sampleStrobe |=> !sampleStrobe [*8]) else $error("strobes too close");
  cover property (disable iff (sys_rst) $rose(converterRunning));
  cover property (disable iff (hostRst) underrun);
  cover property (disable iff (hostRst) $fell(sampleReady));
  cover property (disable iff (sys_rst) jointZeroMode && rightZeroFlag);
endmodule

//--- audio_link_if.sv
// Purpose: three-wire serial audio link between source and converter
// Assumes: source drives all three wires, converter only listens
// Notes: bit clock is made by the source
`timescale 1ns/1ns
interface audio_link_if;
  logic audioBitClock;
  logic wordSelectClock;
  logic serialData;
  modport device(input audioBitClock, input wordSelectClock, input serialData);
  modport host(output audioBitClock, output wordSelectClock, output serialData);
endinterface

//--- audio_pkg.sv
// Purpose: shared constants, format codes and helpers of the serial audio link
// Assumes: 24-bit sample path, MSB-aligned two's complement words
// Notes: format codes are the 3-bit input format field values
package audio_pkg;
  localparam int SAMPLE_W = 24;
  localparam int REF_CLK_PERIOD_NS = 8;
  localparam logic [2:0] FMT_RJ16 = 3'h0;
  localparam logic [2:0] FMT_RJ20 = 3'h1;
  localparam logic [2:0] FMT_RJ24 = 3'h2;
  localparam logic [2:0] FMT_RJ18 = 3'h3;
  localparam logic [2:0] FMT_I2S = 3'h4;
  localparam logic [2:0] FMT_LJ = 3'h5;
  localparam logic [2:0] FMT_RESET = FMT_LJ;
  localparam int INIT_CYCLES = 1024;
  localparam int SYNC_PERIODS = 2;
  localparam int MUTE_PERIODS = 3;
  localparam int STALL_BIT_PERIODS = 3;
  localparam int RATE_TOL = 4;
  localparam int SLOT_BITS_DEF = 32;
  localparam int HALF_DIV_DEF = 2;
  localparam int FIFO_DEPTH_DEF = 2;
  localparam logic [SAMPLE_W-1:0] BIPOLAR_ZERO = 24'h000000;

  typedef enum logic [1:0] {MODE_RJ, MODE_I2S, MODE_LJ} format_mode_e;

  function automatic format_mode_e fmtMode(input logic [2:0] f);
    if (f == FMT_I2S) return MODE_I2S;
    if (f <= FMT_RJ18) return MODE_RJ;
    return MODE_LJ;
  endfunction

  // word length for right-justified codes; framed formats take up to 24 bits
  function automatic logic [4:0] fmtLength(input logic [2:0] f);
    case (f)
      FMT_RJ16: return 5'h10;
      FMT_RJ20: return 5'h14;
      FMT_RJ18: return 5'h12;
      default: return 5'h18;
    endcase
  endfunction

  // word select level that marks the left channel
  function automatic logic leftLevel(input format_mode_e m);
    return (m == MODE_I2S) ? 1'b0 : 1'b1;
  endfunction
endpackage

//--- audio_source_host.sv
// Purpose: serial audio source: bit clock divider, framing, two-entry buffer
// Assumes: bit clock and word select derived from ref_clk
// Notes: an empty buffer at frame start sends a zero frame
`timescale 1ns/1ns
module audio_source_host #(
  parameter int SLOT_BITS = audio_pkg::SLOT_BITS_DEF,
  parameter int HALF_DIV = audio_pkg::HALF_DIV_DEF,
  parameter int FIFO_DEPTH = audio_pkg::FIFO_DEPTH_DEF
) (
  input wire logic ref_clk, // master clock
  input wire logic sys_rst, // async reset, high
  audio_link_if.host link, // serial audio output
  input wire logic [2:0] inputFormatField, // format to send
  input wire logic [audio_pkg::SAMPLE_W-1:0] sampleLeft, // left word
  input wire logic [audio_pkg::SAMPLE_W-1:0] sampleRight, // right word
  input wire logic sampleValid, // pair offered
  output logic sampleReady, // pair accepted when valid
  output logic underrun // pulse: zero frame sent
);
  import audio_pkg::*;

  if (!(SLOT_BITS == 16 || SLOT_BITS == 24 || SLOT_BITS == 32) || HALF_DIV < 1
      || HALF_DIV > 255 || FIFO_DEPTH != 2 ** $clog2(FIFO_DEPTH) || FIFO_DEPTH < 2)
    begin : gBadParam
    $error("audio_source_host: unsupported parameter value");
  end

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int PAIR_W = 2 * SAMPLE_W;

  ////////////////////////////////////////////////////////////////////////////
  // pair buffer
  logic [PAIR_W-1:0] mem_reg [FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;
  logic fifoEmpty;

  assign fifoEmpty = count_reg == '0;
  assign sampleReady = count_reg != (PTR_W + 1)'(FIFO_DEPTH);
  assign push = sampleValid && sampleReady;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wrPtr_reg] <= {sampleLeft, sampleRight};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit clock divider and framing
  logic [7:0] divCnt_reg;
  logic bck_reg;
  logic ws_reg;
  logic data_reg;
  logic [4:0] slotBit_reg;
  logic chanRight_reg;
  logic [PAIR_W-1:0] pair_reg;
  logic tick;
  logic fallTick;
  logic [4:0] nextBit;
  logic nextRight;
  logic frameStart;
  logic [PAIR_W-1:0] pairSel;
  format_mode_e mode;
  logic [4:0] wordLen;

  // MSB-first bit at slot position k, or zero outside the word
  function automatic logic slotData(input logic [SAMPLE_W-1:0] w, input format_mode_e m,
                                    input logic [4:0] len, input logic [4:0] k);
    int idx;
    idx = 0;
    case (m)
      MODE_I2S: idx = int'(k) - 1;
      MODE_RJ: idx = int'(k) - (SLOT_BITS - int'(len));
      default: idx = int'(k);
    endcase
    if (idx < 0 || idx >= int'(len)) return 1'b0;
    return w[SAMPLE_W - 1 - idx];
  endfunction

  always_comb begin
    mode = fmtMode(inputFormatField);
    wordLen = fmtLength(inputFormatField);
    tick = divCnt_reg == 8'(HALF_DIV - 1);
    fallTick = tick && bck_reg;
    nextBit = (slotBit_reg == 5'(SLOT_BITS - 1)) ? 5'h00 : slotBit_reg + 5'h01;
    nextRight = (nextBit == 5'h00) ? ~chanRight_reg : chanRight_reg;
    frameStart = fallTick && nextBit == 5'h00 && !nextRight;
    pop = frameStart && !fifoEmpty;
    if (frameStart) begin
      pairSel = fifoEmpty ? '0 : mem_reg[rdPtr_reg];
    end else begin
      pairSel = pair_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_reg <= 8'h00;
      bck_reg <= 1'b0;
    end else begin
      divCnt_reg <= tick ? 8'h00 : divCnt_reg + 8'h01;
      if (tick) begin
        bck_reg <= ~bck_reg;
      end
    end
  end

  // word select and data change on the falling bit clock edge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slotBit_reg <= 5'(SLOT_BITS - 1);
      chanRight_reg <= 1'b1;
      ws_reg <= 1'b0;
      data_reg <= 1'b0;
      pair_reg <= '0;
      underrun <= 1'b0;
    end else begin
      underrun <= frameStart && fifoEmpty;
      if (fallTick) begin
        slotBit_reg <= nextBit;
        chanRight_reg <= nextRight;
        pair_reg <= pairSel;
        ws_reg <= nextRight ? ~leftLevel(mode) : leftLevel(mode);
        if (nextRight) begin
          data_reg <= slotData(pairSel[SAMPLE_W-1:0], mode, wordLen, nextBit);
        end else begin
          data_reg <= slotData(pairSel[PAIR_W-1:SAMPLE_W], mode, wordLen, nextBit);
        end
      end
    end
  end

  assign link.audioBitClock = bck_reg;
  assign link.wordSelectClock = ws_reg;
  assign link.serialData = data_reg;
endmodule

//--- tb_top.sv
// Purpose: self-checking bench joining source and converter over the link
// Assumes: short init count, 32-bit slots, bit clock ref_clk/4
// Notes: source reset is held to stop the link clocks and force a resync
`timescale 1ns/1ns
module tb_top;
  import audio_pkg::*;
  localparam int INIT_CNT = 16;
  typedef struct packed {
    logic [2:0] fmt;
    logic wr;
    logic joint;
    logic [23:0] l, r, eL, eR;
    logic zL, zR;
  } row_s;
  localparam row_s ROWS[9] = '{
    '{FMT_LJ, 1'b0, 1'b0, 24'h8ABCDE, 24'h123456, 24'h8ABCDE, 24'h123456, 1'b0, 1'b0},
    '{FMT_I2S, 1'b1, 1'b0, 24'h7FFFFF, 24'h800001, 24'h7FFFFF, 24'h800001, 1'b0, 1'b0},
    '{FMT_RJ16, 1'b1, 1'b0, 24'h8ABCDE, 24'h123456, 24'h8ABC00, 24'h123400, 1'b0, 1'b0},
    '{FMT_RJ18, 1'b1, 1'b0, 24'h8ABCDE, 24'h123456, 24'h8ABCC0, 24'h123440, 1'b0, 1'b0},
    '{FMT_RJ20, 1'b1, 1'b0, 24'h8ABCDE, 24'h123456, 24'h8ABCD0, 24'h123450, 1'b0, 1'b0},
    '{FMT_RJ24, 1'b1, 1'b0, 24'h8ABCDE, 24'h123456, 24'h8ABCDE, 24'h123456, 1'b0, 1'b0},
    '{3'h6, 1'b1, 1'b0, 24'h000000, 24'h00F000, 24'h000000, 24'h00F000, 1'b1, 1'b0},
    '{FMT_LJ, 1'b1, 1'b1, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 1'b0, 1'b1},
    '{FMT_LJ, 1'b1, 1'b1, 24'h000000, 24'h000100, 24'h000000, 24'h000100, 1'b0, 1'b0}};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b0;
  logic hostHold, hostRst, formatWrite, jointZeroMode, sampleValid, logOn;
  logic [2:0] devFmt, hostFmt;
  logic [SAMPLE_W-1:0] sampleLeft, sampleRight, leftChannelOutput, rightChannelOutput;
  logic sampleStrobe, leftZeroFlag, rightZeroFlag, converterRunning, sampleReady, underrun;
  logic [15:0] measuredRatio;
  logic [SAMPLE_W-1:0] seenQ[$];
  int bad_count = 0;
  int n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  assign hostRst = sys_rst | hostHold;
  audio_link_if link();
  audio_dac_front #(.INIT_COUNT(INIT_CNT)) audio_dac_front_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .link(link), .inputFormatField(devFmt), .formatWrite(formatWrite),
    .jointZeroMode(jointZeroMode), .leftChannelOutput(leftChannelOutput),
    .rightChannelOutput(rightChannelOutput), .sampleStrobe(sampleStrobe),
    .leftZeroFlag(leftZeroFlag), .rightZeroFlag(rightZeroFlag),
    .converterRunning(converterRunning), .measuredRatio(measuredRatio));
  audio_source_host audio_source_host_inst (.ref_clk(ref_clk), .sys_rst(hostRst), .link(link),
    .inputFormatField(hostFmt), .sampleLeft(sampleLeft), .sampleRight(sampleRight),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .underrun(underrun));
  audio_link_asserts #(.INIT_COUNT(INIT_CNT)) audio_link_asserts_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .hostRst(hostRst), .audioBitClock(link.audioBitClock),
    .wordSelectClock(link.wordSelectClock), .serialData(link.serialData),
    .converterRunning(converterRunning), .leftChannelOutput(leftChannelOutput),
    .rightChannelOutput(rightChannelOutput), .sampleStrobe(sampleStrobe),
    .leftZeroFlag(leftZeroFlag), .rightZeroFlag(rightZeroFlag),
    .jointZeroMode(jointZeroMode), .measuredRatio(measuredRatio),
    .sampleReady(sampleReady), .underrun(underrun));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (logOn && sampleStrobe === 1'b1) seenQ.push_back(leftChannelOutput);
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // bounded wait for normal conversion
  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (converterRunning !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check(converterRunning, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    wait_cycles(60000);
    bad_count++;
    stop_test();
  end
  initial begin
    int ia, ib, nc;
    sys_rst <= 1'b1;
    hostHold = 1'b0;
    formatWrite = 1'b0;
    jointZeroMode = 1'b0;
    sampleValid = 1'b0;
    logOn = 1'b0;
    devFmt = FMT_LJ;
    hostFmt = FMT_LJ;
    sampleLeft = 24'h000000;
    sampleRight = 24'h000000;
    #1;
    check({link.audioBitClock, link.wordSelectClock, link.serialData, underrun}, 4'h0);
    check({sampleReady, converterRunning, leftChannelOutput}, {2'b10, 24'h000000});
    wait_cycles(2);
    sys_rst <= 1'b0;
    repeat (INIT_CNT) begin
      @(posedge ref_clk);
      #1;
      check({converterRunning, leftChannelOutput, rightChannelOutput}, 49'h0);
    end
    // each row stops the link, sets the row's format while the link is stopped (row 0 without a write), then resyncs
    foreach (ROWS[i]) begin
      @(posedge ref_clk);
      hostHold <= 1'b1;
      hostFmt <= ROWS[i].fmt;
      devFmt <= ROWS[i].fmt;
      formatWrite <= ROWS[i].wr;
      jointZeroMode <= ROWS[i].joint;
      sampleLeft <= ROWS[i].l;
      sampleRight <= ROWS[i].r;
      sampleValid <= 1'b1;
      @(posedge ref_clk);
      formatWrite <= 1'b0;
      wait_cycles(40);
      #1;
      if (i > 0) check({converterRunning, leftChannelOutput}, 25'h0);
      @(posedge ref_clk);
      hostHold <= 1'b0;
      wait_run(1800);
      wait_cycles(600);
      #1;
      check(leftChannelOutput, ROWS[i].eL);
      check(rightChannelOutput, ROWS[i].eR);
      check({leftZeroFlag, rightZeroFlag}, {ROWS[i].zL, ROWS[i].zR});
    end
    // drain to empty, then fill until refused
    @(posedge ref_clk);
    sampleValid <= 1'b0;
    nc = 0;
    while (underrun !== 1'b1 && nc < 800) begin
      @(posedge ref_clk);
      #1;
      nc++;
    end
    check({underrun, sampleReady}, 2'b11);
    @(posedge ref_clk);
    logOn <= 1'b1;
    sampleValid <= 1'b1;
    sampleLeft <= 24'h5A5A01;
    @(posedge ref_clk);
    sampleLeft <= 24'h5A5A02;
    @(posedge ref_clk);
    sampleLeft <= 24'h5A5A03;
    #1;
    check(sampleReady, 1'b0);
    wait_cycles(40);
    sampleValid <= 1'b0;
    wait_cycles(1200);
    ia = -1;
    ib = -1;
    nc = 0;
    foreach (seenQ[k]) begin
      if (seenQ[k] === 24'h5A5A01 && ia < 0) ia = k;
      if (seenQ[k] === 24'h5A5A02 && ib < 0) ib = k;
      if (seenQ[k] === 24'h5A5A03) nc++;
    end
    check({ia >= 0, ib > ia, nc == 0}, 3'b111);
    // second reset: a format write during init is ignored
    sys_rst <= 1'b1;
    wait_cycles(2);
    sys_rst <= 1'b0;
    wait_cycles(3);
    formatWrite <= 1'b1;
    devFmt <= FMT_I2S;
    sampleLeft <= 24'h6B0102;
    sampleRight <= 24'h94FEFD;
    sampleValid <= 1'b1;
    @(posedge ref_clk);
    formatWrite <= 1'b0;
    wait_run(1900);
    wait_cycles(600);
    #1;
    check({leftChannelOutput, rightChannelOutput}, {24'h6B0102, 24'h94FEFD});
    stop_test();
  end
endmodule
